// ===== mac_stall_regs.svh
// timing counts and stage counts of the multiply-accumulate interlock
`ifndef MAC_STALL_REGS_SVH
`define MAC_STALL_REGS_SVH

// multiplier busy cycles after the final memory-access stage
`define MAC_LONG_BUSY_CYCLES 4
`define MAC_WORD_BUSY_CYCLES 2
// stage count of the double-length multiply-accumulate
`define MAC_LONG_STAGE_COUNT 9
// busy counter width
`define MAC_BUSY_CNT_W 3

`endif

// ===== mac_stall_pkg.sv
// instruction classes seen by the multiply-accumulate interlock
package mac_stall_pkg;

	typedef enum logic [3:0] {
		INSN_OTHER,
		INSN_LONG_MULTIPLY_ACCUMULATE,
		INSN_WORD_MULTIPLY_ACCUMULATE,
		INSN_SIGNED_DOUBLE_MULTIPLY,
		INSN_SIGNED_WORD_MULTIPLY,
		INSN_STORE_SYSREG_TO_GPR,
		INSN_STORE_SYSREG_TO_MEMORY,
		INSN_LOAD_SYSREG_FROM_GPR,
		INSN_LOAD_SYSREG_FROM_MEMORY
	} insn_class_e;

endpackage

// ===== mult_busy_counter.sv
// down counter that marks the multiplier busy period
`include "mac_stall_regs.svh"

module mult_busy_counter #(
	parameter int CNT_W = `MAC_BUSY_CNT_W
) (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic             load,
	input  wire logic [CNT_W-1:0] loadValue,
	output logic                  busy,
	output logic      [CNT_W-1:0] count
);

	logic [CNT_W-1:0] count_ff;

	generate
		if (CNT_W < 1) begin : g_bad_width
			$error("busy counter width must be at least one bit");
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			count_ff <= '0;
		end else if (load) begin
			count_ff <= loadValue;
		end else if (count_ff != '0) begin
			count_ff <= count_ff - 1'b1;
		end
	end

	assign busy  = (count_ff != '0);
	assign count = count_ff;

endmodule

// ===== mac_multiplier_stall_control.sv
// interlock of multiply-accumulate stages against the multiplier and instruction fetch
`include "mac_stall_regs.svh"

// Contract
// - memory-load of sysreg gets multiplier access stage
// - that stage stretches until multiplier finishes
// - that stage arbitrates against instruction fetch
// - long multiply-accumulate runs nine stages
// - second access stage reads and feeds multiplier
// - multiplier busy four cycles after last access
// - follower decode stalls one slot
// - both access stages split slots with fetch; here fetch gets no slot while either access stage is valid
// - non-multiplier follower only stalls one slot
// - detect contention for every multiplier-using follower
// - second access stage extended over busy period
// - two non-multiplier instructions between avoid stall
module mac_multiplier_stall_control #(
	parameter int CNT_W     = `MAC_BUSY_CNT_W,
	parameter int LONG_BUSY = `MAC_LONG_BUSY_CYCLES,
	parameter int WORD_BUSY = `MAC_WORD_BUSY_CYCLES
) (
	input  wire logic                      clk_sys,
	input  wire logic                      rst,
	input  wire logic                      decValid,
	input  mac_stall_pkg::insn_class_e     decClass,
	input  wire logic                      fetchReq,
	output logic                           decAccept,
	output logic                           decStall,
	output logic                           fetchGrant,
	output logic                           accessGrant,
	output logic                           multAccess,
	output logic                           multContention,
	output logic                           mulOperandLoad,
	output logic                           mulStart,
	output logic                           mulBusy,
	output logic                           exValid,
	output mac_stall_pkg::insn_class_e     exClass,
	output logic                           maValid,
	output mac_stall_pkg::insn_class_e     maClass,
	output logic                           maSecond
);

	generate
		if (LONG_BUSY < 1 || LONG_BUSY >= (1 << CNT_W) || WORD_BUSY < 1
				|| WORD_BUSY >= (1 << CNT_W)) begin : g_bad_busy
			$error("busy cycle counts must fit the busy counter");
		end
	endgenerate

	localparam logic [CNT_W-1:0] LONG_LOAD = CNT_W'(LONG_BUSY);
	localparam logic [CNT_W-1:0] WORD_LOAD = CNT_W'(WORD_BUSY);

	logic                       exValid_ff;
	mac_stall_pkg::insn_class_e exClass_ff;
	logic                       maValid_ff;
	mac_stall_pkg::insn_class_e maClass_ff;
	logic                       maSecond_ff;
	logic                       maWait;
	logic                       maDone;
	logic                       maFinal;
	logic                       maFree;
	logic                       exMove;
	logic                       exFree;
	logic [CNT_W-1:0]           busyLoad;
	logic [CNT_W-1:0]           busyCount;

	function automatic logic usesMult(input mac_stall_pkg::insn_class_e c);
		return c != mac_stall_pkg::INSN_OTHER;
	endfunction

	// classes that run two memory-access stages, the second touching the multiplier
	function automatic logic twoAccess(input mac_stall_pkg::insn_class_e c);
		return c == mac_stall_pkg::INSN_LONG_MULTIPLY_ACCUMULATE
			|| c == mac_stall_pkg::INSN_WORD_MULTIPLY_ACCUMULATE
			|| c == mac_stall_pkg::INSN_SIGNED_DOUBLE_MULTIPLY;
	endfunction

	function automatic logic startsMult(input mac_stall_pkg::insn_class_e c);
		return twoAccess(c) || c == mac_stall_pkg::INSN_SIGNED_WORD_MULTIPLY;
	endfunction

	function automatic logic touchesMult(input mac_stall_pkg::insn_class_e c, input logic second);
		return usesMult(c) && (!twoAccess(c) || second);
	endfunction

	// memory stage that reaches the multiplier; sysreg load from memory included
	assign multAccess = maValid_ff && touchesMult(maClass_ff, maSecond_ff);
	// stage stretched over the busy period and closed in its last cycle, as one slot;
	// closing one cycle later would stall even behind two unrelated spacers
	assign maWait = multAccess && (busyCount > CNT_W'(1));
	assign multContention = maWait;
	assign maDone = maValid_ff && !maWait;
	assign maFinal = maDone && (!twoAccess(maClass_ff) || maSecond_ff);
	assign maFree = !maValid_ff || maFinal;
	assign exMove = exValid_ff && maFree;
	assign exFree = !exValid_ff || exMove;

	// memory access owns the bus in every access-stage cycle; fetch takes only cycles with no access stage valid
	assign accessGrant = maValid_ff;
	assign fetchGrant = fetchReq && !maValid_ff;

	// follower decode held one slot while the long form sits in execute
	assign decStall = decValid && ((exValid_ff
		&& exClass_ff == mac_stall_pkg::INSN_LONG_MULTIPLY_ACCUMULATE) || !exFree);
	assign decAccept = decValid && !decStall;

	assign mulOperandLoad = maDone && multAccess;
	assign mulStart = maFinal && startsMult(maClass_ff);
	assign busyLoad = (maClass_ff == mac_stall_pkg::INSN_LONG_MULTIPLY_ACCUMULATE
		|| maClass_ff == mac_stall_pkg::INSN_SIGNED_DOUBLE_MULTIPLY) ? LONG_LOAD : WORD_LOAD;

	// only multiplier users are tracked past decode; others leave no interlock
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			exValid_ff <= 1'b0;
			exClass_ff <= mac_stall_pkg::INSN_OTHER;
		end else if (exFree) begin
			exValid_ff <= decAccept && usesMult(decClass);
			exClass_ff <= decClass;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			maValid_ff  <= 1'b0;
			maClass_ff  <= mac_stall_pkg::INSN_OTHER;
			maSecond_ff <= 1'b0;
		end else if (maDone && !maFinal) begin
			maSecond_ff <= 1'b1;
		end else if (maFree) begin
			maValid_ff  <= exMove;
			maClass_ff  <= exClass_ff;
			maSecond_ff <= 1'b0;
		end
	end

	mult_busy_counter #(
		.CNT_W     (CNT_W)
	) u_busy (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.load      (mulStart),
		.loadValue (busyLoad),
		.busy      (mulBusy),
		.count     (busyCount)
	);

	assign exValid  = exValid_ff;
	assign exClass  = exClass_ff;
	assign maValid  = maValid_ff;
	assign maClass  = maClass_ff;
	assign maSecond = maSecond_ff;

	sequence seqLongStart;
		mulStart && maClass_ff == mac_stall_pkg::INSN_LONG_MULTIPLY_ACCUMULATE;
	endsequence

	sequence seqLongBusy;
		mulBusy [*3] ##1 (mulBusy && busyCount == CNT_W'(1));
	endsequence

	sequence seqLastBusyAccess;
		multAccess && busyCount == CNT_W'(1);
	endsequence

	sequence seqLongFirstDone;
		maDone && !maSecond_ff && maClass_ff == mac_stall_pkg::INSN_LONG_MULTIPLY_ACCUMULATE;
	endsequence

	AST_LONG_BUSY_FOUR: assert property (@(posedge clk_sys) disable iff (rst)
		seqLongStart |=> seqLongBusy)
		else $error("multiplier busy period after long form is not four cycles");

	AST_FOLLOWER_STALL: assert property (@(posedge clk_sys) disable iff (rst)
		exValid_ff && exClass_ff == mac_stall_pkg::INSN_LONG_MULTIPLY_ACCUMULATE && decValid
		|-> decStall && !decAccept)
		else $error("follower decode not stalled behind long form");

	AST_STAGE_STRETCH: assert property (@(posedge clk_sys) disable iff (rst)
		maWait |=> maValid_ff && $stable(maClass_ff) && $stable(maSecond_ff))
		else $error("multiplier stage left while multiplier busy");

	AST_SECOND_EXTENDED: assert property (@(posedge clk_sys) disable iff (rst)
		seqLongFirstDone |=> maValid_ff && maSecond_ff
		&& (mulOperandLoad == (busyCount <= CNT_W'(1))))
		else $error("second access stage not held over busy period");

	AST_FETCH_SPLIT: assert property (@(posedge clk_sys) disable iff (rst)
		fetchReq && maValid_ff |-> accessGrant && !fetchGrant)
		else $error("fetch and memory access granted together");

	AST_TWO_ACCESS: assert property (@(posedge clk_sys) disable iff (rst)
		seqLongFirstDone |-> !mulOperandLoad ##1 (maValid_ff && maSecond_ff))
		else $error("long form did not run two access stages");

	AST_SYSREG_LOAD: assert property (@(posedge clk_sys) disable iff (rst)
		maValid_ff && maClass_ff == mac_stall_pkg::INSN_LOAD_SYSREG_FROM_MEMORY
		&& busyCount > CNT_W'(1)
		|-> multContention && !mulOperandLoad)
		else $error("sysreg load from memory ignored multiplier busy");

	AST_NO_IDLE_STALL: assert property (@(posedge clk_sys) disable iff (rst)
		maValid_ff && !mulBusy |-> maDone)
		else $error("access stage stalled with multiplier idle");

	AST_COUNTER_DOWN: assert property (@(posedge clk_sys) disable iff (rst)
		busyCount != '0 && !mulStart |=> busyCount == $past(busyCount) - 1'b1)
		else $error("busy counter did not count down");

	AST_LAST_SLOT_HANDOVER: assert property (@(posedge clk_sys) disable iff (rst)
		seqLastBusyAccess |-> mulOperandLoad && !multContention)
		else $error("access stage not closed in the last busy cycle");

	AST_SINGLE_SLOT_STALL: assert property (@(posedge clk_sys) disable iff (rst)
		decValid && exValid_ff && exClass_ff == mac_stall_pkg::INSN_LONG_MULTIPLY_ACCUMULATE
		&& !maValid_ff |=> !decStall)
		else $error("decode behind long form stalled more than one slot");

	AST_SECOND_OWNS_BUS: assert property (@(posedge clk_sys) disable iff (rst)
		maValid_ff && maSecond_ff |-> accessGrant && !fetchGrant)
		else $error("second access stage lost the bus to fetch");

endmodule

// ===== mem_bus_model.sv
// far-side model of the bus: fetch requests that compete with access stages
module mem_bus_model (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic fetchGrant,
	output logic      fetchReq
);
	timeunit 1ns;
	timeprecision 1ps;

	int seed = 97;

	// a refused fetch stays requested until a cycle with no access stage valid hands it the bus
	always @(posedge clk_sys) begin
		if (rst || !fetchReq || fetchGrant) begin
			fetchReq <= #1 (($random(seed) % 4) != 0);
		end
	end
endmodule

// ===== tb_top.sv
// self-checking bench of the multiply-accumulate interlock
`include "mac_stall_regs.svh"
`define CHK(nm, e, g) begin cmpCount++; if ((g) !== (e)) begin miscompares++; \
	$display("BAD %s exp %0h got %0h", nm, e, g); end end

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic                       clk_sys     = 1'b0;
	logic                       rst         = 1'b1;
	logic                       decValid    = 1'b0;
	mac_stall_pkg::insn_class_e decClass    = mac_stall_pkg::INSN_OTHER;
	mac_stall_pkg::insn_class_e fc;
	logic                       fetchReq, decAccept, decStall, fetchGrant, accessGrant;
	logic                       multContention, mulBusy, maValid, firstStall;
	logic                       mulOperandLoad, mulStart, exValid, maSecond;
	mac_stall_pkg::insn_class_e maClass, expCls;
	mac_stall_pkg::insn_class_e clsQ[$];
	logic                       contSeen    = 1'b0;
	int                         miscompares = 0;
	int                         cmpCount    = 0;
	int                         cyc         = 0;
	int                         run         = 0;
	int                         exCnt       = 0;
	int                         expBusy;
	int                         expQ[$];

	always #4 clk_sys = ~clk_sys;

	mac_multiplier_stall_control dut_u (.clk_sys(clk_sys), .rst(rst), .decValid(decValid),
		.decClass(decClass), .fetchReq(fetchReq), .decAccept(decAccept), .decStall(decStall),
		.fetchGrant(fetchGrant), .accessGrant(accessGrant), .multAccess(),
		.multContention(multContention), .mulOperandLoad(mulOperandLoad),
		.mulStart(mulStart), .mulBusy(mulBusy), .exValid(exValid), .exClass(),
		.maValid(maValid), .maClass(maClass), .maSecond(maSecond));

	mem_bus_model bus_u (.clk_sys(clk_sys), .rst(rst), .fetchGrant(fetchGrant),
		.fetchReq(fetchReq));

	function automatic int busyOf(input mac_stall_pkg::insn_class_e c);
		case (c)
			mac_stall_pkg::INSN_LONG_MULTIPLY_ACCUMULATE: return `MAC_LONG_BUSY_CYCLES;
			mac_stall_pkg::INSN_SIGNED_DOUBLE_MULTIPLY:   return `MAC_LONG_BUSY_CYCLES;
			mac_stall_pkg::INSN_WORD_MULTIPLY_ACCUMULATE: return `MAC_WORD_BUSY_CYCLES;
			mac_stall_pkg::INSN_SIGNED_WORD_MULTIPLY:     return `MAC_WORD_BUSY_CYCLES;
			default:                                      return 0;
		endcase
	endfunction

	// classes whose multiplier handover happens in a second access stage
	function automatic logic twoStage(input mac_stall_pkg::insn_class_e c);
		return c == mac_stall_pkg::INSN_LONG_MULTIPLY_ACCUMULATE
			|| c == mac_stall_pkg::INSN_WORD_MULTIPLY_ACCUMULATE
			|| c == mac_stall_pkg::INSN_SIGNED_DOUBLE_MULTIPLY;
	endfunction

	// valid stays up between back-to-back issues so it never toggles in one step
	task automatic issue(input mac_stall_pkg::insn_class_e c);
		logic ok;
		int   n;
		n = 0;
		decValid = 1'b1;
		decClass = c;
		do begin
			@(negedge clk_sys);
			if (n == 0) firstStall = decStall;
			ok = decAccept;
			@(posedge clk_sys);
			#1;
			n++;
		end while (ok !== 1'b1 && n < 40);
	endtask

	task automatic give_verdict();
		if (miscompares == 0 && cmpCount > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		@(posedge clk_sys);
		#1;
		for (int f = 0; f < 9; f++) begin
			for (int g = 0; g < 3; g++) begin
				fc = mac_stall_pkg::insn_class_e'(f);
				contSeen = 1'b0;
				exCnt = 0;
				expQ.push_back(`MAC_LONG_BUSY_CYCLES);
				if (busyOf(fc) > 0) expQ.push_back(busyOf(fc));
				clsQ.push_back(mac_stall_pkg::INSN_LONG_MULTIPLY_ACCUMULATE);
				if (fc != mac_stall_pkg::INSN_OTHER) clsQ.push_back(fc);
				issue(mac_stall_pkg::INSN_LONG_MULTIPLY_ACCUMULATE);
				issue(g == 0 ? fc : mac_stall_pkg::INSN_OTHER);
				`CHK("decStall", 1'b1, firstStall)
				for (int k = 1; k < g; k++) issue(mac_stall_pkg::INSN_OTHER);
				if (g > 0) issue(fc);
				decValid = 1'b0;
				decClass = mac_stall_pkg::INSN_OTHER;
				repeat (20) @(posedge clk_sys);
				#1;
				// with two spacers only the long form has a stated outcome
				if (g < 2 || fc == mac_stall_pkg::INSN_LONG_MULTIPLY_ACCUMULATE) begin
					`CHK("contention", (fc != mac_stall_pkg::INSN_OTHER && g < 2), contSeen)
				end
				`CHK("exValid cycles", (fc != mac_stall_pkg::INSN_OTHER) ? 2 : 1, exCnt)
			end
		end
		`CHK("notes left", 0, expQ.size())
		`CHK("class notes left", 0, clsQ.size())
		give_verdict();
	end

	// outputs looked at mid-cycle, well clear of the edge that launches them
	always @(negedge clk_sys) begin
		cyc++;
		if (!rst) begin
			if (multContention === 1'b1) contSeen = 1'b1;
			if (exValid === 1'b1) exCnt++;
			`CHK("fetchGrant", fetchReq && !maValid, fetchGrant)
			`CHK("accessGrant", maValid, accessGrant)
			if (mulOperandLoad === 1'b1) begin
				expCls = (clsQ.size() > 0) ? clsQ.pop_front() : mac_stall_pkg::INSN_OTHER;
				`CHK("maClass", expCls, maClass)
				`CHK("maSecond", twoStage(expCls), maSecond)
			end
			if (mulBusy === 1'b1) run++;
			// a reload in the last busy cycle closes the old run without a gap
			if ((mulStart === 1'b1 || mulBusy !== 1'b1) && run > 0) begin
				expBusy = (expQ.size() > 0) ? expQ.pop_front() : -1;
				`CHK("busy run", expBusy, run)
				run = 0;
			end
		end
		if (cyc == 6000) begin
			miscompares++;
			give_verdict();
		end
	end
endmodule
